// file: logic/pcpwm_pkg.sv
// Constants and types for the dual-slope PWM timer pair
// What this block does
// RL1: Modes 1 and 5 count up then down
// RL2: TOP is 0xFF in mode 1, compare A in 5
// RL3: Non-inverting: clear on up match, set on down
// RL4: Inverting: set on up match, clear on down
// RL5: Hold TOP one tick, then count down
// RL6: Overflow flag set on reaching BOTTOM
// RL7: Action two non-inverted, three inverted PWM
// RL8: Action 01 toggles A when high mode bit set
// RL9: Nonzero action lets output A override port
// RL10: Software sets pin direction to drive it
// RL11: Period is 510 ticks of prescaled clock in mode 1, twice compare A in 5
// RL12: Non-inverting: compare BOTTOM constant low, MAX constant high
// RL13: Level at MAX matches up-count match result
// RL14: Missed up match repaired at BOTTOM
// RL15: Fully synchronous, tick only a clock enable
// RL16: Non-PWM actions: off, toggle, clear, set
// RL17: Fast PWM: match clears or sets, TOP reverses
// RL18: Compare equal TOP: act at TOP instead
// RL19: Control A field layout, bits 3:2 zero
// RL20: Third mode bit lives in control B
// RL21: Output B phase-correct actions, 01 reserved
// RL22: Compare writes take effect at TOP in PWM modes, a clock later otherwise
// RL23: Reset: BOTTOM, counting up, outputs low, off
package pcpwm_pkg;
    // Register offsets, index 1 is timer 1, index 0 timer 0
    localparam logic [1:0][7:0] OFF_CTRL_A = {8'h2f, 8'h30};
    localparam logic [1:0][7:0] OFF_CTRL_B = {8'h2e, 8'h33};
    localparam logic [1:0][7:0] OFF_COUNT  = {8'h2d, 8'h32};
    localparam logic [1:0][7:0] OFF_CMP_A  = {8'h2c, 8'h36};
    localparam logic [1:0][7:0] OFF_CMP_B  = {8'h2b, 8'h3c};
    localparam logic [7:0]      OFF_FLAGS  = 8'h38;
    // Field positions
    localparam int ACT_A_LSB    = 6;
    localparam int ACT_B_LSB    = 4;
    localparam int MODE_LO_LSB  = 0;
    localparam int MODE_HI_BIT  = 3;
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    localparam logic [7:0] RESET_VAL    = 8'h00;
    localparam logic [7:0] BOTTOM       = 8'h00;
    localparam logic [7:0] MAX          = 8'hff;
    localparam int PC_PERIOD_TICKS      = 510;
    // Waveform modes
    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_PC_MAX  = 3'h1;
    localparam logic [2:0] MODE_CTC     = 3'h2;
    localparam logic [2:0] MODE_FP_MAX  = 3'h3;
    localparam logic [2:0] MODE_PC_CMP  = 3'h5;
    localparam logic [2:0] MODE_FP_CMP  = 3'h7;
    // Output actions
    localparam logic [1:0] ACT_OFF      = 2'h0;
    localparam logic [1:0] ACT_TOGGLE   = 2'h1;
    localparam logic [1:0] ACT_CLEAR    = 2'h2;
    localparam logic [1:0] ACT_SET      = 2'h3;
    // Register select codes
    localparam logic [2:0] SEL_NONE  = 3'h0;
    localparam logic [2:0] SEL_CTLA  = 3'h1;
    localparam logic [2:0] SEL_CTLB  = 3'h2;
    localparam logic [2:0] SEL_CNT   = 3'h3;
    localparam logic [2:0] SEL_CMPA  = 3'h4;
    localparam logic [2:0] SEL_CMPB  = 3'h5;
    localparam logic [2:0] SEL_FLAGS = 3'h6;

    typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} pcpwm_dir_t;
endpackage : pcpwm_pkg

// file: logic/pcpwm_top.sv
// Two 8-bit timers with phase correct PWM and compare outputs
`timescale 1ns/100ps
module pcpwm_top
    import pcpwm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] timer_tick_enable,
    output logic      [1:0] wave_out_a,
    output logic      [1:0] wave_out_b,
    output logic      [1:0] pin_override_a,
    output logic      [1:0] pin_override_b,
    output logic      [1:0] overflow_flag
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic       mode_hi;
        logic [7:0] cnt;
        pcpwm_dir_t dir;
        logic [7:0] cmpa_buf;
        logic [7:0] cmpb_buf;
        logic [7:0] cmpa;
        logic [7:0] cmpb;
        logic       wave_a;
        logic       wave_b;
        logic       ovr_a;
        logic       ovr_b;
        logic       ovf;
    } pcpwm_tmr_t;

    typedef struct packed {
        pcpwm_tmr_t [1:0] tm;
        logic [7:0]       rdata;
    } pcpwm_state_t;

    pcpwm_state_t s_reg;
    pcpwm_state_t s_next;

    // Decode an address into {timer, register select}
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        logic [3:0] r;
        r = {1'b0, SEL_NONE};
        if (a == OFF_FLAGS) r = {1'b0, SEL_FLAGS};
        for (int i = 0; i < 2; i++) begin
            if (a == OFF_CTRL_A[i]) r = {i[0], SEL_CTLA};
            if (a == OFF_CTRL_B[i]) r = {i[0], SEL_CTLB};
            if (a == OFF_COUNT[i])  r = {i[0], SEL_CNT};
            if (a == OFF_CMP_A[i])  r = {i[0], SEL_CMPA};
            if (a == OFF_CMP_B[i])  r = {i[0], SEL_CMPB};
        end
        return r;
    endfunction : reg_sel

    // TOP value for a mode
    function automatic logic [7:0] top_of(input logic [2:0] m, input logic [7:0] ca);
        logic [7:0] t;
        t = MAX;                                            // RL2
        if (m == MODE_PC_CMP || m == MODE_FP_CMP || m == MODE_CTC) t = ca; // RL2
        return t;
    endfunction : top_of

    // New compare output level on one tick
    function automatic logic wave_step(input logic [2:0] m, input logic [1:0] act,
                                       input logic is_a, input logic [7:0] cnt,
                                       input logic [7:0] cmp, input pcpwm_dir_t d,
                                       input logic [7:0] tp, input logic old);
        logic       r;
        logic       pc;
        logic       fp;
        logic       hit;
        logic       at_top;
        logic [7:0] top;
        top    = 8'h00;
        r      = old;
        pc     = (m == MODE_PC_MAX) || (m == MODE_PC_CMP);
        fp     = (m == MODE_FP_MAX) || (m == MODE_FP_CMP);
        hit    = (cnt == cmp);
        top    = tp;                                        // RL2
        at_top = (cnt == top);
        if (pc || fp) begin
            if (act == ACT_TOGGLE) begin
                if (is_a && m[2] && hit) r = ~old;          // RL8
            end else if (act[1]) begin                      // RL7
                if (fp) begin
                    if (at_top) r = ~act[0];                // RL17 RL18
                    else if (hit) r = act[0];               // RL17
                end else if (cmp == top) begin
                    if (at_top) r = ~act[0];                // RL18 RL12
                end else if (hit) begin
                    if (d == DIR_DOWN && cnt != BOTTOM) r = ~act[0]; // RL3 RL4 RL21
                    else r = act[0];                        // RL3 RL4 RL12
                end else if (cnt == BOTTOM) begin
                    r = ~act[0];                            // RL13 RL14
                end
            end
        end else if (hit) begin
            unique case (act)                               // RL16
                ACT_OFF:    r = old;
                ACT_TOGGLE: r = ~old;
                ACT_CLEAR:  r = 1'b0;
                ACT_SET:    r = 1'b1;
            endcase
        end
        return r;
    endfunction : wave_step

    // Next state: bus access, counting, outputs and flags
    always_comb begin
        logic [3:0] wsel;
        logic [3:0] rsel;
        logic [2:0] m;
        logic [7:0] top;
        logic [7:0] c;
        logic       pwm;
        logic       tick;
        logic       at_top;
        wsel   = reg_sel(reg_addr);
        rsel   = reg_sel(reg_addr);
        m      = 3'h0;
        top    = 8'h00;
        c      = 8'h00;
        pwm    = 1'b0;
        tick   = 1'b0;
        at_top = 1'b0;
        s_next = s_reg;
        s_next.rdata = 8'h00;
        for (int i = 0; i < 2; i++) begin
            m      = {s_reg.tm[i].mode_hi, s_reg.tm[i].ctrl_a[MODE_LO_LSB +: 2]}; // RL20
            top    = top_of(m, s_reg.tm[i].cmpa);
            c      = s_reg.tm[i].cnt;
            pwm    = (m == MODE_PC_MAX) || (m == MODE_PC_CMP) ||
                     (m == MODE_FP_MAX) || (m == MODE_FP_CMP);
            tick   = timer_tick_enable[i];                  // RL15
            at_top = (c == top);
            // Compare values
            if (!pwm) begin
                s_next.tm[i].cmpa = s_reg.tm[i].cmpa_buf;
                s_next.tm[i].cmpb = s_reg.tm[i].cmpb_buf;
            end else if (tick && at_top) begin
                s_next.tm[i].cmpa = s_reg.tm[i].cmpa_buf;  // RL22
                s_next.tm[i].cmpb = s_reg.tm[i].cmpb_buf;  // RL22
            end
            if (tick) begin
                // Outputs switch on the tick's compare state
                s_next.tm[i].wave_a = wave_step(m, s_reg.tm[i].ctrl_a[ACT_A_LSB +: 2],
                    1'b1, c, s_reg.tm[i].cmpa, s_reg.tm[i].dir, top, s_reg.tm[i].wave_a);
                s_next.tm[i].wave_b = wave_step(m, s_reg.tm[i].ctrl_a[ACT_B_LSB +: 2],
                    1'b0, c, s_reg.tm[i].cmpb, s_reg.tm[i].dir, top, s_reg.tm[i].wave_b);
                // Counting sequence
                if (m == MODE_PC_MAX || m == MODE_PC_CMP) begin
                    if (s_reg.tm[i].dir == DIR_UP) begin
                        if (c >= top) begin
                            s_next.tm[i].dir = DIR_DOWN;    // RL5
                            s_next.tm[i].cnt = (c == BOTTOM) ? BOTTOM : c - 8'h01; // RL1
                        end else begin
                            s_next.tm[i].cnt = c + 8'h01;   // RL1 RL11
                        end
                    end else if (c == BOTTOM) begin
                        s_next.tm[i].dir = DIR_UP;          // RL1
                        s_next.tm[i].cnt = (top == BOTTOM) ? BOTTOM : 8'h01;
                    end else begin
                        s_next.tm[i].cnt = c - 8'h01;       // RL1 RL11
                        if (c == 8'h01) s_next.tm[i].ovf = 1'b1; // RL6
                    end
                end else if (m == MODE_FP_MAX || m == MODE_FP_CMP) begin
                    s_next.tm[i].cnt = at_top ? BOTTOM : c + 8'h01;
                    if (at_top) s_next.tm[i].ovf = 1'b1;
                end else if (m == MODE_CTC) begin
                    s_next.tm[i].cnt = at_top ? BOTTOM : c + 8'h01;
                    if (c == MAX) s_next.tm[i].ovf = 1'b1;
                end else begin
                    s_next.tm[i].cnt = c + 8'h01;
                    if (c == MAX) s_next.tm[i].ovf = 1'b1;
                end
            end
            // Pin override follows the action fields
            s_next.tm[i].ovr_a = |s_reg.tm[i].ctrl_a[ACT_A_LSB +: 2]; // RL9
            s_next.tm[i].ovr_b = |s_reg.tm[i].ctrl_a[ACT_B_LSB +: 2];
        end
        // Register writes; a counter write beats the tick
        if (reg_wr) begin
            unique case (wsel[2:0])
                SEL_CTLA:  s_next.tm[wsel[3]].ctrl_a = reg_wdata & CTRL_A_WMASK; // RL19
                SEL_CTLB:  s_next.tm[wsel[3]].mode_hi = reg_wdata[MODE_HI_BIT]; // RL20
                SEL_CNT:   s_next.tm[wsel[3]].cnt = reg_wdata;
                SEL_CMPA:  s_next.tm[wsel[3]].cmpa_buf = reg_wdata;
                SEL_CMPB:  s_next.tm[wsel[3]].cmpb_buf = reg_wdata;
                SEL_FLAGS: begin
                    // Write one clears, a same-cycle set of a clear flag wins
                    for (int i = 0; i < 2; i++) begin
                        if (reg_wdata[i] && s_next.tm[i].ovf == s_reg.tm[i].ovf)
                            s_next.tm[i].ovf = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Register reads, data one cycle later
        if (reg_rd) begin
            unique case (rsel[2:0])
                SEL_CTLA:  s_next.rdata = s_reg.tm[rsel[3]].ctrl_a & CTRL_A_WMASK; // RL19
                SEL_CTLB:  s_next.rdata = {4'h0, s_reg.tm[rsel[3]].mode_hi, 3'h0};
                SEL_CNT:   s_next.rdata = s_reg.tm[rsel[3]].cnt;
                SEL_CMPA:  s_next.rdata = s_reg.tm[rsel[3]].cmpa_buf;
                SEL_CMPB:  s_next.rdata = s_reg.tm[rsel[3]].cmpb_buf;
                SEL_FLAGS: s_next.rdata = {6'h00, s_reg.tm[1].ovf, s_reg.tm[0].ovf};
                default:   s_next.rdata = 8'h00;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_reg <= '0;                                    // RL23
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = s_reg.rdata;
    generate
        for (genvar g = 0; g < 2; g++) begin : g_out
            assign wave_out_a[g]     = s_reg.tm[g].wave_a;
            assign wave_out_b[g]     = s_reg.tm[g].wave_b;
            assign pin_override_a[g] = s_reg.tm[g].ovr_a;   // RL9 RL10
            assign pin_override_b[g] = s_reg.tm[g].ovr_b;
            assign overflow_flag[g]  = s_reg.tm[g].ovf;
        end
    endgenerate

    // Checks on timer 0
    logic [2:0] m0;
    logic [7:0] top0;
    logic       pc0;
    assign m0   = {s_reg.tm[0].mode_hi, s_reg.tm[0].ctrl_a[1:0]};
    assign top0 = top_of(m0, s_reg.tm[0].cmpa);
    assign pc0  = (m0 == MODE_PC_MAX) || (m0 == MODE_PC_CMP);

    // Checks on timer 1, where compare A can be TOP
    logic [2:0] m1;
    logic [7:0] top1;
    logic       pc1;
    assign m1   = {s_reg.tm[1].mode_hi, s_reg.tm[1].ctrl_a[1:0]};
    assign top1 = top_of(m1, s_reg.tm[1].cmpa);
    assign pc1  = (m1 == MODE_PC_MAX) || (m1 == MODE_PC_CMP);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    reserved_reads_a: assert property (                              // RL19
        reg_rd && reg_addr == OFF_CTRL_A[0] |=> reg_rdata[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");
    count_up_a: assert property (                                    // RL1
        pc0 && timer_tick_enable[0] && !reg_wr && s_reg.tm[0].dir == DIR_UP
        && s_reg.tm[0].cnt < top0
        |=> s_reg.tm[0].cnt == $past(s_reg.tm[0].cnt) + 8'h01)
        else $error("phase correct count did not rise");
    top_turn_a: assert property (                                    // RL5
        pc0 && timer_tick_enable[0] && !reg_wr && s_reg.tm[0].dir == DIR_UP
        && s_reg.tm[0].cnt == top0 && top0 != BOTTOM
        |=> s_reg.tm[0].dir == DIR_DOWN && s_reg.tm[0].cnt == top0 - 8'h01)
        else $error("counter did not turn at top");
    bottom_flag_a: assert property (                                 // RL6
        pc0 && timer_tick_enable[0] && !reg_wr && s_reg.tm[0].dir == DIR_DOWN
        && s_reg.tm[0].cnt == 8'h01 |=> overflow_flag[0])
        else $error("overflow not set at bottom");
    tick_gate_a: assert property (                                   // RL15
        !timer_tick_enable[0] && !reg_wr |=> $stable(s_reg.tm[0].cnt))
        else $error("counter moved without tick");
    up_clear_a: assert property (                                    // RL3
        pc0 && timer_tick_enable[0] && s_reg.tm[0].ctrl_a[7:6] == ACT_CLEAR
        && s_reg.tm[0].dir == DIR_UP && s_reg.tm[0].cnt == s_reg.tm[0].cmpa
        && s_reg.tm[0].cmpa != top0 |=> !wave_out_a[0])
        else $error("up match did not clear output");
    up_set_a: assert property (                                      // RL4
        pc0 && timer_tick_enable[0] && s_reg.tm[0].ctrl_a[7:6] == ACT_SET
        && s_reg.tm[0].dir == DIR_UP && s_reg.tm[0].cnt == s_reg.tm[0].cmpa
        && s_reg.tm[0].cmpa != top0 |=> wave_out_a[0])
        else $error("up match did not set output");
    override_a: assert property (                                    // RL9
        ##1 pin_override_a[0] == (|$past(s_reg.tm[0].ctrl_a[7:6])))
        else $error("override does not follow action");
    cmp_hold_a: assert property (                                    // RL22
        pc0 && $past(pc0) && !($past(timer_tick_enable[0])
        && $past(s_reg.tm[0].cnt) == $past(top0)) |-> $stable(s_reg.tm[0].cmpa))
        else $error("compare changed away from top");
    reset_state_a: assert property (                                 // RL23
        disable iff (1'b0) $past(sys_rst) |-> s_reg.tm[0].cnt == BOTTOM
        && s_reg.tm[0].dir == DIR_UP && !wave_out_a[0] && !pin_override_a[0])
        else $error("reset state wrong");
    // Down slope, the special cases at TOP and BOTTOM, flag clearing and timer 1 checks
    down_count_a: assert property (                                  // RL1
        pc0 && timer_tick_enable[0] && !reg_wr && s_reg.tm[0].dir == DIR_DOWN
        && s_reg.tm[0].cnt != BOTTOM |=> s_reg.tm[0].cnt == $past(s_reg.tm[0].cnt) - 8'h01)
        else $error("phase correct count did not fall");
    down_set_a: assert property (                                    // RL3
        pc0 && timer_tick_enable[0] && s_reg.tm[0].ctrl_a[7:6] == ACT_CLEAR
        && s_reg.tm[0].dir == DIR_DOWN && s_reg.tm[0].cnt == s_reg.tm[0].cmpa
        && s_reg.tm[0].cmpa != top0 && s_reg.tm[0].cnt != BOTTOM |=> wave_out_a[0])
        else $error("down match did not set output");
    down_clear_a: assert property (                                  // RL4
        pc0 && timer_tick_enable[0] && s_reg.tm[0].ctrl_a[7:6] == ACT_SET
        && s_reg.tm[0].dir == DIR_DOWN && s_reg.tm[0].cnt == s_reg.tm[0].cmpa
        && s_reg.tm[0].cmpa != top0 && s_reg.tm[0].cnt != BOTTOM |=> !wave_out_a[0])
        else $error("down match did not clear output");
    bottom_fix_a: assert property (                                  // RL14
        pc0 && timer_tick_enable[0] && s_reg.tm[0].ctrl_a[7] && s_reg.tm[0].cnt == BOTTOM
        && s_reg.tm[0].cmpa != BOTTOM && s_reg.tm[0].cmpa != top0
        |=> wave_out_a[0] == !$past(s_reg.tm[0].ctrl_a[6]))
        else $error("no symmetry change at bottom");
    top_act_a: assert property (                                     // RL18
        pc0 && timer_tick_enable[0] && s_reg.tm[0].ctrl_a[7] && s_reg.tm[0].cmpa == top0
        && s_reg.tm[0].cnt == top0 |=> wave_out_a[0] == !$past(s_reg.tm[0].ctrl_a[6]))
        else $error("no action at top");
    flag_clear_a: assert property (                                  // RL6
        reg_wr && reg_addr == OFF_FLAGS && reg_wdata[0] && !timer_tick_enable[0]
        |=> !overflow_flag[0])
        else $error("overflow flag not cleared");
    top5_turn_a: assert property (                                   // RL2
        pc1 && timer_tick_enable[1] && !reg_wr && s_reg.tm[1].dir == DIR_UP
        && s_reg.tm[1].cnt == top1 && top1 != BOTTOM |=> s_reg.tm[1].dir == DIR_DOWN)
        else $error("timer 1 did not turn at top");
    b_up_clear_a: assert property (                                  // RL21
        pc1 && timer_tick_enable[1] && s_reg.tm[1].ctrl_a[5:4] == ACT_CLEAR
        && s_reg.tm[1].dir == DIR_UP && s_reg.tm[1].cnt == s_reg.tm[1].cmpb
        && s_reg.tm[1].cmpb != top1 |=> !wave_out_b[1])
        else $error("up match did not clear output b");

    pc_turn_c: cover property (pc0 && s_reg.tm[0].dir == DIR_DOWN ##1
        s_reg.tm[0].dir == DIR_UP);
    ovf_clear_c: cover property (overflow_flag[0] ##1 !overflow_flag[0]);
    wave_rise_c: cover property (pc0 && $rose(wave_out_a[0]));
    b_fall_c: cover property (pc1 && $fell(wave_out_b[1]));
    toggle_c: cover property (m0 == MODE_PC_CMP &&
        s_reg.tm[0].ctrl_a[7:6] == ACT_TOGGLE && $changed(wave_out_a[0]));
endmodule : pcpwm_top

// file: bench/test_phase_correct_pwm_compare_output.sv
// Self-checking bench for the dual-slope PWM timer pair
`timescale 1ns/100ps
module test_phase_correct_pwm_compare_output
    import pcpwm_pkg::*;
;
    logic       clk;
    logic       sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [1:0] timer_tick_enable;
    logic [1:0] wave_out_a;
    logic [1:0] wave_out_b;
    logic [1:0] pin_override_a;
    logic [1:0] pin_override_b;
    logic [1:0] overflow_flag;
    int         fails = 0;
    int         n_compared = 0;
    int         cyc = 0;
    logic [7:0] rv;

    pcpwm_top dut (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .timer_tick_enable (timer_tick_enable),
        .wave_out_a        (wave_out_a),
        .wave_out_b        (wave_out_b),
        .pin_override_a    (pin_override_a),
        .pin_override_b    (pin_override_b),
        .overflow_flag     (overflow_flag)
    );

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    // Register byte compare
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    // Cycle count compare
    task automatic chk_cnt(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // One-cycle read strobe, data taken in the following cycle
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        rv = reg_rdata;
        chk_reg(rv, exp);
    endtask : rdc

    // Single tick on one timer
    task automatic step(input int i);
        @(posedge clk);
        timer_tick_enable[i] <= 1'b1;
        @(posedge clk);
        timer_tick_enable[i] <= 1'b0;
    endtask : step

    // Selects one waveform output: a0, b0, a1, b1
    function automatic logic sig(input int sel);
        logic [3:0] w;
        w = {wave_out_b[1], wave_out_a[1], wave_out_b[0], wave_out_a[0]};
        return w[sel];
    endfunction : sig

    // High time and period between rising edges
    task automatic meas(input int sel, output int hi, output int per);
        logic p;
        logic c;
        hi = 0;
        @(negedge clk);
        p = sig(sel);
        c = p;
        for (int n = 0; n < 2000; n++) begin
            @(negedge clk);
            c = sig(sel);
            if (c === 1'b1 && p === 1'b0) break;
            p = c;
        end
        for (per = 1; per < 2000; per++) begin
            hi += (c === 1'b1) ? 1 : 0;
            @(negedge clk);
            p = c;
            c = sig(sel);
            if (c === 1'b1 && p === 1'b0) break;
        end
    endtask : meas

    // Second measured period is checked, the first may straddle a setting change
    task automatic meas_chk(input int sel, input int exp_hi, input int exp_per);
        int hi;
        int per;
        meas(sel, hi, per);
        meas(sel, hi, per);
        chk_cnt(hi, exp_hi);
        chk_cnt(per, exp_per);
    endtask : meas_chk

    // Output must hold one level for a whole period once settled
    task automatic hold_chk(input int sel, input logic exp);
        int bad;
        bad = 0;
        repeat (1100) @(negedge clk);
        repeat (520) begin
            @(negedge clk);
            if (sig(sel) !== exp) bad++;
        end
        chk_cnt(bad, 0);
    endtask : hold_chk

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        timer_tick_enable = 2'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk_reg({wave_out_a, wave_out_b, pin_override_a, pin_override_b}, 8'h00);
        rdc(OFF_CTRL_A[0], 8'h00);
        rdc(OFF_CTRL_A[1], 8'h00);
        rdc(OFF_COUNT[0], 8'h00);
        wr(OFF_CTRL_A[0], 8'hff);
        rdc(OFF_CTRL_A[0], 8'hf3);
        wr(OFF_CTRL_A[1], 8'h0c);
        rdc(OFF_CTRL_A[1], 8'h00);
        rdc(8'h00, 8'h00);
        // Stepping through TOP and BOTTOM one tick at a time
        wr(OFF_CTRL_A[0], 8'h81);
        wr(OFF_COUNT[0], 8'hfe);
        @(negedge clk);
        chk_reg({6'h00, pin_override_a}, 8'h01);
        step(0);
        rdc(OFF_COUNT[0], 8'hff);
        step(0);
        rdc(OFF_COUNT[0], 8'hfe);
        wr(OFF_COUNT[0], 8'h02);
        step(0);
        rdc(OFF_COUNT[0], 8'h01);
        rdc(OFF_FLAGS, 8'h00);
        step(0);
        rdc(OFF_COUNT[0], 8'h00);
        rdc(OFF_FLAGS, 8'h01);
        chk_reg({6'h00, overflow_flag}, 8'h01);
        step(0);
        rdc(OFF_COUNT[0], 8'h01);
        wr(OFF_FLAGS, 8'h01);
        rdc(OFF_FLAGS, 8'h00);
        // Free-running waveforms on timer 0
        wr(OFF_CMP_A[0], 8'h03);
        @(posedge clk);
        timer_tick_enable <= 2'h1;
        meas_chk(0, 6, 510);
        wr(OFF_CTRL_A[0], 8'hc1);
        meas_chk(0, 504, 510);
        wr(OFF_CMP_A[0], 8'h00);
        wr(OFF_CTRL_A[0], 8'h81);
        hold_chk(0, 1'b0);
        wr(OFF_CMP_A[0], 8'hff);
        hold_chk(0, 1'b1);
        wr(OFF_CTRL_A[0], 8'hc1);
        hold_chk(0, 1'b0);
        wr(OFF_CTRL_A[0], 8'h40);
        wr(OFF_CMP_A[0], 8'h03);
        meas_chk(0, 256, 512);
        // Timer 1 with compare A as TOP
        wr(OFF_CTRL_B[1], 8'h08);
        rdc(OFF_CTRL_B[1], 8'h08);
        wr(OFF_CMP_A[1], 8'h0a);
        wr(OFF_CMP_B[1], 8'h02);
        wr(OFF_CTRL_A[1], 8'h21);
        @(posedge clk);
        timer_tick_enable <= 2'h3;
        @(negedge clk);
        chk_reg({6'h00, pin_override_b}, 8'h02);
        meas_chk(3, 4, 20);
        wr(OFF_CTRL_A[1], 8'h61);
        meas_chk(2, 20, 40);
        tally_and_finish();
    end
endmodule : test_phase_correct_pwm_compare_output
